/* File: dual_channel_ddc_control.v */
// feature path control of a dual-channel converter: registers, routing, filters
//
// Notes on behaviour
// (RQ1) averaging enabled gives (A+B)/2 stream
// (RQ2) software enables mux, code 11, filter, path
// (RQ3) select routes straight, A both, B both, average
// (RQ4) path select clear bypasses features, set includes
// (RQ5) one enable switches both decimation filters
// (RQ6) select codes act only with enable set
// (RQ7) ratio field: bypass, then 2 to 32
// (RQ8) real output: low-pass only, no mixing
// (RQ9) software zeroes tuning word in real mode
// (RQ10) invert bit negates oscillator phase
// (RQ11) per-channel mixer gain 0, 3, 6 dB
// (RQ12) toggle restarts phase, loads new tuning word
// (RQ13) quarter-rate mixing per channel, complex only
// (RQ14) each channel holds 32-bit tuning word
// (RQ15) reserved bits written zero, ignored by device
// (RQ16) all fields reset to zero
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "ddc_ctrl_regs.vh"
module dual_channel_ddc_control #(
    parameter W = 14
) (
    input  wire          clk,
    input  wire          rst_n,
    // register bus
    input  wire [7:0]    avs_address,
    input  wire          avs_read,
    input  wire          avs_write,
    input  wire [31:0]   avs_writedata,
    input  wire [3:0]    avs_byteenable,
    output reg  [31:0]   avs_readdata,
    output wire          avs_waitrequest,
    // samples from the converter cores
    input  wire          sample_valid,
    output wire          sample_ready,
    input  wire [W-1:0]  sample_a,
    input  wire [W-1:0]  sample_b,
    // samples towards the output interface
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W+1:0]  out_i_a,
    output wire [W+1:0]  out_q_a,
    output wire [W+1:0]  out_i_b,
    output wire [W+1:0]  out_q_b
);
    localparam OW = W + 2;      // width of one output word
    localparam BW = 4 * OW;     // width of one buffered entry

    // configuration registers
    reg  [7:0]   digital_path_config;  // routing and path select
    reg  [7:0]   decimation_config;    // ratio, real mode, phase
    reg  [7:0]   mixer_config;         // per-channel mixer controls
    reg  [31:0]  tuning_a;             // oscillator word, channel A
    reg  [31:0]  tuning_b;             // oscillator word, channel B

    // bus handshake state
    reg          bus_ack;              // answer cycle of a request
    reg  [31:0]  next_readdata;        // decoded read value

    // oscillator restart edge detection
    reg          orst_a_prev;          // last seen reset bit A
    reg          orst_b_prev;          // last seen reset bit B

    // buffer and channel wiring
    wire         buf_in_ready;         // buffer can take a word
    wire         chan_valid_a;         // word ready from A
    wire         chan_valid_b;         // word ready from B
    wire [OW-1:0] ch_i_a;
    wire [OW-1:0] ch_q_a;
    wire [OW-1:0] ch_i_b;
    wire [OW-1:0] ch_q_b;
    wire [BW-1:0] buf_out;

    // bus decode
    wire [5:0]   word_index = avs_address[7:2];
    wire         bus_req    = avs_read | avs_write;
    wire         do_write   = avs_write & bus_ack;

    // configuration fields
    wire         avg_enable  = digital_path_config[`POS_AVG_EN];
    wire [1:0]   route_code  = digital_path_config[`POS_SEL_HI:`POS_SEL_LO];
    wire         feature_on  = digital_path_config[`POS_FEATURE];
    wire         ddc_enable  = digital_path_config[`POS_DOWNCONVERTER_ENABLE];
    wire         sel_enable  = decimation_config[`POS_SEL_EN];
    wire [2:0]   ratio       = decimation_config[`POS_RATIO_HI:`POS_RATIO_LO];
    wire         real_mode   = decimation_config[`POS_REAL];
    wire         phase_inv   = decimation_config[`POS_PH_INV];
    wire [1:0]   gain_a      = mixer_config[`POS_GAIN_A_HI:`POS_GAIN_A_LO];
    wire [1:0]   gain_b      = mixer_config[`POS_GAIN_B_HI:`POS_GAIN_B_LO];
    wire         orst_a      = mixer_config[`POS_ORST_A];
    wire         orst_b      = mixer_config[`POS_ORST_B];
    wire         qmix_a      = mixer_config[`POS_QMIX_A];
    wire         qmix_b      = mixer_config[`POS_QMIX_B];
    wire [1:0]   eff_route;    // routing in force
    wire         path_active;  // feature block in path
    wire         decimating;   // filters running

    // merge a byte-enabled write into a word
    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] wdata;
        input [3:0]  be;
        integer k;
        begin
            merge_bytes = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k])
                    merge_bytes[8*k +: 8] = wdata[8*k +: 8];
            end
        end
    endfunction

    // mean of two samples
    function [W-1:0] average;
        input [W-1:0] a;
        input [W-1:0] b;
        reg   [W:0]   s;
        begin
            s = {a[W-1], a} + {b[W-1], b};
            average = s[W:1];
        end
    endfunction


    // register bus slave


    // first cycle of every request waits, second answers
    assign avs_waitrequest = bus_req & ~bus_ack;

    // answer strobe
    always @(posedge clk) begin
        if (!rst_n) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // register writes, reserved bits dropped
    always @(posedge clk) begin
        if (!rst_n) begin
            digital_path_config <= `RST_DIGITAL_PATH;  // RQ16
            decimation_config   <= `RST_DECIMATION;    // RQ16
            mixer_config        <= `RST_MIXER;         // RQ16
            tuning_a            <= `RST_TUNING;        // RQ16
            tuning_b            <= `RST_TUNING;        // RQ16
        end else if (do_write) begin
            case (word_index)
                `IDX_DIGITAL_PATH: begin
                    if (avs_byteenable[0])
                        digital_path_config <= avs_writedata[7:0]
                                             & `MASK_DIGITAL_PATH;  // RQ15
                end
                `IDX_DECIMATION: begin
                    if (avs_byteenable[0])
                        decimation_config <= avs_writedata[7:0]
                                           & `MASK_DECIMATION;  // RQ15
                end
                `IDX_MIXER: begin
                    if (avs_byteenable[0])
                        mixer_config <= avs_writedata[7:0] & `MASK_MIXER;
                end
                `IDX_TUNING_A: begin
                    tuning_a <= merge_bytes(tuning_a, avs_writedata,
                                            avs_byteenable);  // RQ14
                end
                `IDX_TUNING_B: begin
                    tuning_b <= merge_bytes(tuning_b, avs_writedata,
                                            avs_byteenable);  // RQ14
                end
                default: begin
                    // unmapped: write ignored
                end
            endcase
        end
    end

    // read decode
    always @* begin
        case (word_index)
            `IDX_DIGITAL_PATH: next_readdata = {24'h000000, digital_path_config};
            `IDX_DECIMATION:   next_readdata = {24'h000000, decimation_config};
            `IDX_MIXER:        next_readdata = {24'h000000, mixer_config};
            `IDX_TUNING_A:     next_readdata = tuning_a;
            `IDX_TUNING_B:     next_readdata = tuning_b;
            `IDX_STATUS:       next_readdata = {24'h000000, 2'h0,
                                                decimating, path_active,
                                                eff_route, ~buf_in_ready,
                                                out_valid};
            default:           next_readdata = 32'h00000000;
        endcase
    end

    // read data loaded in the wait cycle
    always @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !bus_ack) begin
            avs_readdata <= next_readdata;
        end
    end


    // oscillator restart on a toggle of its own reset bit


    // last seen reset bits
    always @(posedge clk) begin
        if (!rst_n) begin
            orst_a_prev <= 1'b0;
            orst_b_prev <= 1'b0;
        end else begin
            orst_a_prev <= orst_a;
            orst_b_prev <= orst_b;
        end
    end

    wire restart_a = orst_a ^ orst_a_prev;  // RQ12
    wire restart_b = orst_b ^ orst_b_prev;  // RQ12


    // input routing in front of the filters


    // codes act only when enabled
    assign eff_route = sel_enable ? route_code : `ROUTE_STRAIGHT;  // RQ6

    // averaged stream
    wire [W-1:0] avg_sample = average(sample_a, sample_b);  // RQ1

    // feature block and filter state
    assign path_active = feature_on;                 // RQ4
    assign decimating  = feature_on & ddc_enable;    // RQ5

    reg [W-1:0] route_a;   // sample offered to filter A
    reg [W-1:0] route_b;   // sample offered to filter B

    // filter input mux
    always @* begin
        route_a = sample_a;
        route_b = sample_b;
        if (path_active) begin
            case (eff_route)  // RQ3
                `ROUTE_STRAIGHT: begin
                    // defaults hold
                end
                `ROUTE_A_BOTH: begin
                    route_b = sample_a;
                end
                `ROUTE_B_BOTH: begin
                    route_a = sample_b;
                end
                default: begin
                    // averaged, or straight if off
                    if (avg_enable) begin  // RQ1
                        route_a = avg_sample;
                        route_b = avg_sample;
                    end
                end
            endcase
        end
    end


    // the two downconverters


    // path halts while buffer full
    assign sample_ready = buf_in_ready;

    ddc_channel #(
        .W (W)
    ) channel_a (
        .clk          (clk),
        .rst_n        (rst_n),
        .stall        (~buf_in_ready),
        .in_valid     (sample_valid),
        .in_sample    (route_a),
        .process      (decimating),
        .real_mode    (real_mode),
        .phase_invert (phase_inv),
        .quarter_mix  (qmix_a),
        .gain         (gain_a),
        .ratio        (ratio),
        .osc_restart  (restart_a),
        .tuning       (tuning_a),
        .out_valid    (chan_valid_a),
        .out_i        (ch_i_a),
        .out_q        (ch_q_a)
    );

    ddc_channel #(
        .W (W)
    ) channel_b (
        .clk          (clk),
        .rst_n        (rst_n),
        .stall        (~buf_in_ready),
        .in_valid     (sample_valid),
        .in_sample    (route_b),
        .process      (decimating),
        .real_mode    (real_mode),
        .phase_invert (phase_inv),
        .quarter_mix  (qmix_b),
        .gain         (gain_b),
        .ratio        (ratio),
        .osc_restart  (restart_b),
        .tuning       (tuning_b),
        .out_valid    (chan_valid_b),
        .out_i        (ch_i_b),
        .out_q        (ch_q_b)
    );


    // output buffer


    // channels emit together
    pair_buffer #(
        .WIDTH (BW)
    ) out_buffer (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (chan_valid_a & chan_valid_b),
        .in_ready  (buf_in_ready),
        .in_data   ({ch_i_a, ch_q_a, ch_i_b, ch_q_b}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (buf_out)
    );

    // unpack the head entry
    assign out_i_a = buf_out[4*OW-1:3*OW];
    assign out_q_a = buf_out[3*OW-1:2*OW];
    assign out_i_b = buf_out[2*OW-1:OW];
    assign out_q_b = buf_out[OW-1:0];

endmodule

/* File: ddc_ctrl_regs.vh */
// register indices, field positions and reset values of the feature path
`ifndef DDC_CTRL_REGS_VH
`define DDC_CTRL_REGS_VH

// register indices; byte address is four times the index
`define IDX_DIGITAL_PATH   6'h24
`define IDX_DECIMATION     6'h25
`define IDX_MIXER          6'h26
`define IDX_STATUS         6'h28
`define IDX_TUNING_A       6'h2A
`define IDX_TUNING_B       6'h31

// digital_path_config fields
`define POS_AVG_EN         5
`define POS_SEL_HI         4
`define POS_SEL_LO         3
`define POS_FEATURE        2
`define POS_DOWNCONVERTER_ENABLE         1

// decimation_config fields
`define POS_SEL_EN         7
`define POS_RATIO_HI       6
`define POS_RATIO_LO       4
`define POS_REAL           3
`define POS_PH_INV         0

// mixer_config fields
`define POS_GAIN_A_HI      7
`define POS_GAIN_A_LO      6
`define POS_ORST_A         5
`define POS_QMIX_A         4
`define POS_GAIN_B_HI      3
`define POS_GAIN_B_LO      2
`define POS_ORST_B         1
`define POS_QMIX_B         0

// writable bits; all others are reserved and read as zero
`define MASK_DIGITAL_PATH  8'h3E
`define MASK_DECIMATION    8'hF9
`define MASK_MIXER         8'hFF

// reset values
`define RST_DIGITAL_PATH   8'h00
`define RST_DECIMATION     8'h00
`define RST_MIXER          8'h00
`define RST_TUNING         32'h00000000

// filter input routing codes
`define ROUTE_STRAIGHT     2'h0
`define ROUTE_A_BOTH       2'h1
`define ROUTE_B_BOTH       2'h2
`define ROUTE_AVG          2'h3

// mixer gain codes
`define GAIN_3DB           2'h1
`define GAIN_6DB           2'h2

// largest valid decimation ratio code
`define RATIO_MAX          3'h5

// phase step of quarter-rate mixing
`define QUARTER_STEP       32'h40000000

`endif

/* File: pair_buffer.v */
// two-entry valid/ready buffer with registered head
`timescale 1ns/1ps
module pair_buffer #(
    parameter WIDTH = 64
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] head;   // oldest word
    reg [WIDTH-1:0] tail;   // second word
    reg [1:0]       count;  // words held

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = head;

    // storage and occupancy
    always @(posedge clk) begin
        if (!rst_n) begin
            count <= 2'h0;
            head  <= {WIDTH{1'b0}};
            tail  <= {WIDTH{1'b0}};
        end else begin
            if (push && pop) begin
                // one in, one out
                if (count == 2'h1) begin
                    head <= in_data;
                end else begin
                    head <= tail;
                    tail <= in_data;
                end
            end else if (pop) begin
                head  <= tail;
                count <= count - 2'h1;
            end else if (push) begin
                if (count == 2'h0) begin
                    head <= in_data;
                end else begin
                    tail <= in_data;
                end
                count <= count + 2'h1;
            end
        end
    end
endmodule

/* File: ddc_channel.v */
// one downconverter channel: coarse oscillator, mixer, gain, decimator
`timescale 1ns/1ps
`include "ddc_ctrl_regs.vh"
module ddc_channel #(
    parameter W = 14
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          stall,
    input  wire          in_valid,
    input  wire [W-1:0]  in_sample,
    input  wire          process,
    input  wire          real_mode,
    input  wire          phase_invert,
    input  wire          quarter_mix,
    input  wire [1:0]    gain,
    input  wire [2:0]    ratio,
    input  wire          osc_restart,
    input  wire [31:0]   tuning,
    output reg           out_valid,
    output reg  [W+1:0]  out_i,
    output reg  [W+1:0]  out_q
);
    localparam AW = W + 7;

    reg  [31:0]  phase;        // oscillator phase
    reg  [31:0]  tuning_live;  // word in use
    reg  [4:0]   count;        // samples in current block
    reg  signed [AW-1:0] acc_i;
    reg  signed [AW-1:0] acc_q;

    wire take = in_valid & ~stall;
    wire [2:0] eff_ratio = (ratio > `RATIO_MAX) ? 3'h0 : ratio;
    wire [4:0] last = (5'h01 << eff_ratio) - 5'h01;
    wire [1:0] quad = phase_invert ? (2'h0 - phase[31:30]) : phase[31:30]; // RQ10
    wire [31:0] step = quarter_mix ? `QUARTER_STEP : tuning_live;  // RQ13
    wire signed [W:0] x = {in_sample[W-1], in_sample};

    // gain after the mixer: 3 dB approximated as x1.375
    function signed [W+1:0] add_gain;
        input signed [W:0] v;
        input [1:0] code;
        reg signed [W+1:0] e;
        begin
            e = {v[W], v};
            if (code == `GAIN_3DB)
                add_gain = e + (e >>> 2) + (e >>> 3);
            else if (code == `GAIN_6DB)
                add_gain = e <<< 1;
            else
                add_gain = e;
        end
    endfunction

    reg signed [W:0] mi;
    reg signed [W:0] mq;
    // quarter-turn rotation by the oscillator quadrant
    always @* begin
        mi = x;
        mq = {(W+1){1'b0}};
        if (!real_mode) begin  // RQ8
            case (quad)
                2'h0: mi = x;
                2'h1: begin mi = {(W+1){1'b0}}; mq = -x; end
                2'h2: mi = -x;
                default: begin mi = {(W+1){1'b0}}; mq = x; end
            endcase
        end
    end

    wire signed [W+1:0] gi = real_mode ? {mi[W], mi} : add_gain(mi, gain);  // RQ11
    wire signed [W+1:0] gq = real_mode ? {mq[W], mq} : add_gain(mq, gain);  // RQ11
    wire signed [AW-1:0] sum_i = acc_i + {{5{gi[W+1]}}, gi};
    wire signed [AW-1:0] sum_q = acc_q + {{5{gq[W+1]}}, gq};
    wire signed [AW-1:0] avg_i = sum_i >>> eff_ratio;
    wire signed [AW-1:0] avg_q = sum_q >>> eff_ratio;

    // oscillator, accumulate and emit
    always @(posedge clk) begin
        if (!rst_n) begin
            phase       <= 32'h00000000;
            tuning_live <= `RST_TUNING;
            count       <= 5'h00;
            acc_i       <= {AW{1'b0}};
            acc_q       <= {AW{1'b0}};
            out_valid   <= 1'b0;
            out_i       <= {(W+2){1'b0}};
            out_q       <= {(W+2){1'b0}};
        end else begin
            if (osc_restart) begin
                phase       <= 32'h00000000;  // RQ12
                tuning_live <= tuning;        // RQ12
            end else if (take && process && !real_mode) begin
                phase <= phase + step;
            end
            if (!stall) begin
                out_valid <= 1'b0;
            end
            if (take && !process) begin
                // filters off: sample passes straight
                out_valid <= 1'b1;
                out_i     <= {x[W], x};
                out_q     <= {(W+2){1'b0}};
                count     <= 5'h00;
                acc_i     <= {AW{1'b0}};
                acc_q     <= {AW{1'b0}};
            end else if (take) begin
                if (count == last) begin  // RQ7
                    out_valid <= 1'b1;
                    out_i     <= avg_i[W+1:0];
                    out_q     <= avg_q[W+1:0];
                    count     <= 5'h00;
                    acc_i     <= {AW{1'b0}};
                    acc_q     <= {AW{1'b0}};
                end else begin
                    count <= count + 5'h01;
                    acc_i <= sum_i;
                    acc_q <= sum_q;
                end
            end
        end
    end
endmodule

/* File: ddc_ctrl_monitor.sv */
// bus and stream assertions for the feature path block
`timescale 1ns/1ps
module ddc_ctrl_monitor #(parameter W = 14) (
    input wire         clk,
    input wire         rst_n,
    input wire [7:0]   avs_address,
    input wire         avs_read,
    input wire         avs_write,
    input wire [31:0]  avs_readdata,
    input wire         avs_waitrequest,
    input wire         sample_ready,
    input wire         out_valid,
    input wire         out_ready,
    input wire [W+1:0] out_i_a
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire req = avs_read | avs_write;  // any bus request
    wire rok = avs_read & ~avs_waitrequest;  // read completing
    wait_idle_a: assert property (!req |-> !avs_waitrequest)
        else $error("wait while idle");
    wait_once_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    path_rsvd_a: assert property (
        rok && avs_address[7:2] == 6'h24 |-> avs_readdata[31:6] == 26'h0 && !avs_readdata[0])
        else $error("path reserved bits");
    deci_rsvd_a: assert property (
        rok && avs_address[7:2] == 6'h25 |-> avs_readdata[31:8] == 24'h0 && !avs_readdata[2:1])
        else $error("ratio reserved bits");
    reset_clr_a: assert property (
        $rose(rst_n) |-> avs_readdata == 32'h0 && !out_valid && sample_ready)
        else $error("state after reset");
    hold_word_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_i_a))
        else $error("word moved while stalled");
    ready_free_a: assert property (!out_valid |-> sample_ready)
        else $error("refused while empty");
    rdata_keep_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved");
    cover property (rok);
    cover property (out_valid && !out_ready);
    cover property (!sample_ready);
endmodule
bind dual_channel_ddc_control ddc_ctrl_monitor #(.W(W)) i_mon (.clk, .rst_n,
    .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .sample_ready, .out_valid, .out_ready, .out_i_a);

/* File: converter_side.sv */
// converter cores and output receiver on the far side of the block
`timescale 1ns/1ps
module converter_side #(parameter W = 14) (
    input  wire         clk,
    output reg          sample_valid,
    input  wire         sample_ready,
    output reg  [W-1:0] sample_a,
    output reg  [W-1:0] sample_b,
    output reg          out_ready
);
    // quiet lines, receiver ready
    initial begin
        sample_valid = 1'b0;
        sample_a = {W{1'b0}};
        sample_b = {W{1'b0}};
        out_ready = 1'b1;
    end
    // hold a pair until taken, then show inverted data
    task send(input [W-1:0] a, input [W-1:0] b);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_a <= a;
        sample_b <= b;
        @(posedge clk);
        while (sample_ready !== 1'b1) @(posedge clk);
        sample_valid <= 1'b0;
        sample_a <= ~a;
        sample_b <= ~b;
    endtask
    // stall or free the receiver
    task hold(input s);
        out_ready <= ~s;
    endtask
endmodule

/* File: dual_channel_ddc_control_test.sv */
// self-checking bench for the feature path block
`timescale 1ns/1ps
module dual_channel_ddc_control_test;
    localparam W = 14;
    reg          clk = 1'b0;
    reg          rst_n = 1'b0;
    reg  [7:0]   avs_address = 8'h00;
    reg          avs_read = 1'b0;
    reg          avs_write = 1'b0;
    reg  [31:0]  avs_writedata = 32'h0;
    reg  [3:0]   avs_byteenable = 4'hF;
    wire [31:0]  avs_readdata;
    wire         avs_waitrequest, sample_valid, sample_ready, out_valid, out_ready;
    wire [W-1:0] sample_a, sample_b;
    wire [W+1:0] out_i_a, out_q_a, out_i_b, out_q_b;
    reg  [31:0]  rd_val;
    reg  [W+1:0] ea, eb, qs [0:3];
    integer      err_count = 0, samples_checked = 0, k, m, si, sq;
    always #2.5 clk = ~clk;
    dual_channel_ddc_control #(.W(W)) i_dut (.clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .sample_valid, .sample_ready, .sample_a, .sample_b, .out_valid, .out_ready,
        .out_i_a, .out_q_a, .out_i_b, .out_q_b);
    converter_side #(.W(W)) i_side (.clk, .sample_valid, .sample_ready, .sample_a,
        .sample_b, .out_ready);
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task chk4(input [W+1:0] ia, input [W+1:0] qa, input [W+1:0] ib, input [W+1:0] qb);
        chk(out_i_a, ia);
        chk(out_q_a, qa);
        chk(out_i_b, ib);
        chk(out_q_b, qb);
    endtask
    // one bus cycle, held until waitrequest drops
    task bus(input wr, input [7:0] a, input [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd_val = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task wrchk(input [7:0] a, input [31:0] d, input [31:0] e);
        bus(1'b1, a, d);
        bus(1'b0, a, 32'h0);
        chk(rd_val, e);
    endtask
    // wait for and accept one output word
    task take;
        @(posedge clk);
        while (out_valid !== 1'b1) @(posedge clk);
    endtask
    task route(input en, input [1:0] sel, input avg);
        bus(1'b1, 8'h90, {avg, sel, 3'h4});
        bus(1'b1, 8'h94, {en, 7'h10});
        i_side.send(14'h0064, 14'h3FD8);
        take;
    endtask
    task give_verdict;
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        err_count = err_count + 1;
        give_verdict;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (k = 0; k < 3; k = k + 1) begin
            bus(1'b0, 8'h90 + 8'(4 * k), 32'h0);
            chk(rd_val, 32'h0);
        end
        wrchk(8'h90, 32'hFFFFFFFF, 32'h3E);
        wrchk(8'h94, 32'hFFFFFFFF, 32'hF9);
        wrchk(8'h98, 32'hA5, 32'hA5);
        wrchk(8'hFC, 32'h5A, 32'h0);
        wrchk(8'hA8, 32'h89ABCDEF, 32'h89ABCDEF);
        wrchk(8'hC4, 32'h13579BDF, 32'h13579BDF);
        for (k = 0; k < 3; k = k + 1) bus(1'b1, 8'h90 + 8'(4 * k), 32'h0);
        bus(1'b1, 8'hA8, 32'h0);
        bus(1'b1, 8'hC4, 32'h0);
        i_side.send(14'h2ABC, 14'h0123);
        take;
        chk4(16'hEABC, 0, 16'h0123, 0);
        // fill the buffer with the receiver stalled, then drain
        i_side.hold(1'b1);
        i_side.send(14'h0001, 14'h0002);
        i_side.send(14'h0003, 14'h0004);
        repeat (3) @(posedge clk);
        chk(sample_ready, 32'h0);
        i_side.hold(1'b0);
        take;
        chk4(1, 0, 2, 0);
        take;
        chk4(3, 0, 4, 0);
        for (k = 0; k < 4; k = k + 1) begin
            route(1'b1, k[1:0], k == 3);
            ea = k == 2 ? 16'hFFD8 : k == 3 ? 16'h1E : 16'h64;
            eb = k == 1 ? 16'h64 : k == 3 ? 16'h1E : 16'hFFD8;
            chk4(ea, 0, eb, 0);
        end
        route(1'b0, 2'h1, 1'b0);
        chk4(16'h64, 0, 16'hFFD8, 0);
        route(1'b1, 2'h3, 1'b0);
        chk4(16'h64, 0, 16'hFFD8, 0);
        bus(1'b1, 8'h90, 32'h06);
        for (k = 0; k < 6; k = k + 1) begin
            bus(1'b1, 8'h94, {k[2:0], 4'h8});
            for (m = 1; m < (1 << k); m = m + 1)
                i_side.send(14'h0014, 14'h3FEC);
            repeat (3) @(posedge clk);
            chk(out_valid, 32'h0);
            i_side.send(14'h0014, 14'h3FEC);
            take;
            chk4(16'h14, 0, 16'hFFEC, 0);
        end
        bus(1'b1, 8'h94, 32'h0);
        bus(1'b1, 8'h98, 32'h48);
        i_side.send(14'h0010, 14'h0010);
        take;
        chk4(16'h16, 0, 16'h20, 0);
        bus(1'b1, 8'h98, 32'h10);
        bus(1'b1, 8'h98, 32'h30);
        // plain then inverted phase, each after an oscillator restart
        for (k = 0; k < 2; k = k + 1) begin
            si = 0;
            sq = 0;
            for (m = 0; m < 4; m = m + 1) begin
                i_side.send(14'h0040, 14'h0040);
                take;
                si = si + $signed(out_i_a);
                sq = sq + $signed(out_q_a);
                if (k == 0)
                    qs[m] = -out_q_a;
                else
                    chk(out_q_a, qs[m]);
                chk(out_i_b, 16'h40);
            end
            chk(si, 0);
            chk(sq, 0);
            bus(1'b1, 8'h94, 32'h01);
            bus(1'b1, 8'h98, 32'h10);
        end
        bus(1'b1, 8'h94, 32'h08);
        i_side.send(14'h0040, 14'h0040);
        take;
        chk4(16'h40, 0, 16'h40, 0);
        give_verdict;
    end
endmodule
